// ===== rtl/rtc_cal_upper_params.svh
// Purpose: register map and field constants of the upper calendar block
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes:   byte address is four times the register index
`ifndef RTC_CAL_UPPER_PARAMS_SVH
`define RTC_CAL_UPPER_PARAMS_SVH

// register indices
`define IDX_MONTH          10'h0e5
`define IDX_YEAR           10'h0e6
`define IDX_CENTURY        10'h0e7
`define IDX_ALARM_SEC      10'h0e8
`define IDX_ALARM_CTRL     10'h0ec
`define IDX_EVT_STATUS     10'h0f0
`define IDX_EVT_MASK       10'h0f1

// field positions
`define ALARM_CTRL_SEC_EN  0
`define EVT_SEC_MATCH      0
`define EVT_YEAR_STEP      1
`define EVT_CENT_STEP      2
`define EVT_W              3

// count limits, binary and packed decimal
`define MONTH_FIRST        8'h01
`define MONTH_LAST_BIN     8'h0c
`define MONTH_LAST_BCD     8'h12
`define YEAR_LAST_BIN      8'h63
`define YEAR_LAST_BCD      8'h99
`define DIGIT_LAST         4'h9

// reset values of the held control state
`define ALARM_CTRL_RST     1'h0
`define EVT_RST            3'h0

`endif

// ===== rtl/rtc_cal_upper_pkg.sv
// Purpose: shared types of the upper calendar block
// Assumes: constants live in rtc_cal_upper_params.svh
// Notes:   none
package rtc_cal_upper_pkg;
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_type;
    typedef logic [7:0] cal_byte_type;
endpackage

// ===== rtl/rtc_cal_upper.sv
// Purpose: month, year, century counters and alarm seconds compare
// Assumes: day carry, coding select, lock and seconds come from same clock
// Notes:   counter and compare bytes have no reset, as the clock demands
//
// Summary of operation
// - month starts at one after wrap or from an illegal zero
// - binary month holds 01h to 0Ch
// - decimal month: tens 0-1 in high nibble, ones 0-9 in low
// - binary year counts 00h to 63h
// - decimal year holds two digits, tens in high nibble
// - binary century holds 00h to 63h
// - decimal century holds two digits, tens in bits 7:4
// - binary alarm seconds compare holds 00h to 3Bh
// - decimal alarm seconds: tens 0-5, ones 0-9
// - month, year, century keep value through reset
// - alarm seconds keeps value through reset, writable even when locked
// - month, year, century writes ignored while locked
// - month, year, century count as binary or decimal per select; seconds compare is plain byte equality
// - seconds compare matches only when its enable is set; enable resets
`timescale 1ns/1ps
`include "rtc_cal_upper_params.svh"

module rtc_cal_upper #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst,
    // axi4-lite write address and data
    input  wire logic                          i_awvalid,
    output logic                               o_awready,
    input  wire logic [ADDR_W-1:0]             i_awaddr,
    input  wire logic [2:0]                    i_awprot,
    input  wire logic                          i_wvalid,
    output logic                               o_wready,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic [3:0]                    i_wstrb,
    // axi4-lite write response
    output logic                               o_bvalid,
    input  wire logic                          i_bready,
    output rtc_cal_upper_pkg::axi_resp_type    o_bresp,
    // axi4-lite read
    input  wire logic                          i_arvalid,
    output logic                               o_arready,
    input  wire logic [ADDR_W-1:0]             i_araddr,
    input  wire logic [2:0]                    i_arprot,
    output logic                               o_rvalid,
    input  wire logic                          i_rready,
    output logic [31:0]                        o_rdata,
    output rtc_cal_upper_pkg::axi_resp_type    o_rresp,
    // neighbouring clock logic
    input  wire logic                          i_day_carry,
    input  wire logic                          i_bcd_select,
    input  wire logic                          i_locked,
    input  wire logic [7:0]                    i_second_count,
    // results
    output logic                               o_second_match,
    output logic                               o_irq
);
    import rtc_cal_upper_pkg::*;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////
    // state

    cal_byte_type                month_r;
    cal_byte_type                year_r;
    cal_byte_type                century_r;
    cal_byte_type                alarm_sec_r;
    logic                        wake_second_match_enable_r;
    logic [`EVT_W-1:0]           status_r;
    logic [`EVT_W-1:0]           mask_r;
    logic                        match_r;

    logic                        aw_held_r;
    logic                        w_held_r;
    logic [ADDR_W-1:0]           awaddr_r;
    logic [31:0]                 wdata_r;
    logic                        wlane0_r;
    logic                        bvalid_r;
    axi_resp_type                bresp_r;
    logic                        rvalid_r;
    logic [31:0]                 rdata_r;
    axi_resp_type                rresp_r;

    ////////////////////////////////////////////////////////////////////
    // packed-decimal or binary increment of one byte

    function automatic cal_byte_type step_byte(input cal_byte_type v,
                                               input logic bcd);
        cal_byte_type r;
        r = v + 8'h01;
        if (bcd && v[3:0] >= `DIGIT_LAST) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order

    wire logic aw_take   = i_awvalid && o_awready;
    wire logic w_take    = i_wvalid && o_wready;
    wire logic wr_fire   = aw_held_r && w_held_r && !bvalid_r;
    wire logic [9:0] wr_idx = awaddr_r[11:2];
    wire logic wr_align  = awaddr_r[1:0] == 2'h0;

    wire logic sel_w_month = wr_align && wr_idx == `IDX_MONTH;
    wire logic sel_w_year  = wr_align && wr_idx == `IDX_YEAR;
    wire logic sel_w_cent  = wr_align && wr_idx == `IDX_CENTURY;
    wire logic sel_w_wake_second_ones  = wr_align && wr_idx == `IDX_ALARM_SEC;
    wire logic sel_w_actl  = wr_align && wr_idx == `IDX_ALARM_CTRL;
    wire logic sel_w_stat  = wr_align && wr_idx == `IDX_EVT_STATUS;
    wire logic sel_w_mask  = wr_align && wr_idx == `IDX_EVT_MASK;
    wire logic wr_mapped   = sel_w_month || sel_w_year || sel_w_cent ||
                             sel_w_wake_second_ones || sel_w_actl || sel_w_stat ||
                             sel_w_mask;
    // only byte lane 0 carries register bits
    wire logic wr_go       = wr_fire && wlane0_r;
    // a locked counter write still answers okay, it just does nothing
    wire logic wr_cal_ok   = wr_go && !i_locked;
    wire cal_byte_type wbyte = wdata_r[7:0];

    assign o_awready = !aw_held_r && !bvalid_r;
    assign o_wready  = !w_held_r && !bvalid_r;
    assign o_bvalid  = bvalid_r;
    assign o_bresp   = bresp_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wlane0_r  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= i_awaddr;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r  <= i_wdata;
                wlane0_r <= i_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && i_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel

    wire logic ar_take   = i_arvalid && o_arready;
    wire logic [9:0] rd_idx = i_araddr[11:2];
    wire logic rd_align  = i_araddr[1:0] == 2'h0;
    wire logic [`EVT_W-1:0] irq_bits = status_r & mask_r;

    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = rd_align;
        case (rd_idx)
            `IDX_MONTH:      rd_byte = month_r;
            `IDX_YEAR:       rd_byte = year_r;
            `IDX_CENTURY:    rd_byte = century_r;
            `IDX_ALARM_SEC:  rd_byte = alarm_sec_r;
            `IDX_ALARM_CTRL: rd_byte = {7'h00, wake_second_match_enable_r};
            `IDX_EVT_STATUS: rd_byte = {5'h00, status_r};
            `IDX_EVT_MASK:   rd_byte = {5'h00, mask_r};
            default:         rd_hit  = 1'b0;
        endcase
    end

    assign o_arready = !rvalid_r;
    assign o_rvalid  = rvalid_r;
    assign o_rdata   = rdata_r;
    assign o_rresp   = rresp_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && i_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // calendar carry chain

    wire logic [3:0] period_of_year_tens = month_r[7:4];
    wire logic [3:0] period_of_year_ones = month_r[3:0];
    wire logic [3:0] annual_count_tens   = year_r[7:4];
    wire logic [3:0] annual_count_ones   = year_r[3:0];
    wire logic [3:0] hundred_year_tens   = century_r[7:4];
    wire logic [3:0] hundred_year_ones   = century_r[3:0];

    // limits follow the live coding select
    wire cal_byte_type mon_last = i_bcd_select ? `MONTH_LAST_BCD
                                               : `MONTH_LAST_BIN;
    wire cal_byte_type yr_last  = i_bcd_select ? `YEAR_LAST_BCD
                                               : `YEAR_LAST_BIN;

    // an out-of-range month restarts at one rather than running on
    wire logic mon_wrap  = i_day_carry &&
                           (month_r >= mon_last || month_r == 8'h00);
    wire logic yr_wrap   = mon_wrap && year_r >= yr_last;
    wire logic cen_wrap  = yr_wrap && century_r >= yr_last;

    wire cal_byte_type mon_nxt = mon_wrap ? `MONTH_FIRST
                                          : step_byte(month_r, i_bcd_select);
    wire cal_byte_type yr_nxt  = yr_wrap ? 8'h00
                                         : step_byte(year_r, i_bcd_select);
    wire cal_byte_type cen_nxt = cen_wrap ? 8'h00
                                          : step_byte(century_r, i_bcd_select);

    // no reset term: contents survive a device reset
    always_ff @(posedge i_sys_clk) begin
        if (wr_cal_ok && sel_w_month) begin
            month_r <= wbyte;
        end else if (i_day_carry) begin
            month_r <= mon_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (wr_cal_ok && sel_w_year) begin
            year_r <= wbyte;
        end else if (mon_wrap) begin
            year_r <= yr_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (wr_cal_ok && sel_w_cent) begin
            century_r <= wbyte;
        end else if (yr_wrap) begin
            century_r <= cen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alarm seconds compare

    wire logic [3:0] wake_second_tens = alarm_sec_r[7:4];
    wire logic [3:0] wake_second_ones = alarm_sec_r[3:0];

    // writable under lock too, and kept through reset
    always_ff @(posedge i_sys_clk) begin
        if (wr_go && sel_w_wake_second_ones) begin
            alarm_sec_r <= wbyte;
        end
    end

    // both codings compare the whole byte as stored
    wire logic sec_equal = i_second_count == {wake_second_tens,
                                              wake_second_ones};
    wire logic sec_match = wake_second_match_enable_r && sec_equal;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wake_second_match_enable_r <= `ALARM_CTRL_RST;
            match_r                    <= 1'b0;
        end else begin
            match_r <= sec_match;
            if (wr_go && sel_w_actl) begin
                wake_second_match_enable_r <= wbyte[`ALARM_CTRL_SEC_EN];
            end
        end
    end
    assign o_second_match = match_r;

    ////////////////////////////////////////////////////////////////////
    // sticky events and interrupt

    wire logic [`EVT_W-1:0] evt_set = {yr_wrap, mon_wrap,
                                       sec_match && !match_r};
    wire logic [`EVT_W-1:0] evt_clr = (wr_go && sel_w_stat) ?
                                      wbyte[`EVT_W-1:0] : '0;

    // a new event beats a clear in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            status_r <= `EVT_RST;
            mask_r   <= `EVT_RST;
        end else begin
            status_r <= (status_r & ~evt_clr) | evt_set;
            if (wr_go && sel_w_mask) begin
                mask_r <= wbyte[`EVT_W-1:0];
            end
        end
    end
    assign o_irq = |irq_bits;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_dec_carry;
        i_day_carry && !(wr_fire && sel_w_month) && month_r == 8'h12 &&
        i_bcd_select;
    endsequence

    sequence s_locked_write;
        wr_fire && i_locked && !i_day_carry &&
        (sel_w_month || sel_w_year || sel_w_cent);
    endsequence

    sequence s_wake_second_ones_write;
        wr_fire && wlane0_r && sel_w_wake_second_ones;
    endsequence

    a_month_wraps_one: assert property (
        s_dec_carry |=> month_r == `MONTH_FIRST && $past(year_r) != year_r)
        else $error("month did not restart at one");

    a_month_bin_range: assert property (
        i_day_carry && !i_bcd_select && !wr_fire &&
        month_r >= 8'h01 && month_r <= 8'h0c
        |=> month_r >= 8'h01 && month_r <= 8'h0c)
        else $error("binary month left 1..12");

    a_month_bcd_digits: assert property (
        i_day_carry && i_bcd_select && !wr_fire && month_r == 8'h09
        |=> month_r == 8'h10)
        else $error("decimal month digits wrong");

    a_year_bin_wrap: assert property (
        mon_wrap && !i_bcd_select && year_r == 8'h63 && !wr_fire
        |=> year_r == 8'h00)
        else $error("binary year did not wrap at 63h");

    a_year_bcd_step: assert property (
        mon_wrap && i_bcd_select && year_r == 8'h39 && !wr_fire
        |=> year_r == 8'h40)
        else $error("decimal year tens did not step");

    a_cent_bin_step: assert property (
        yr_wrap && !i_bcd_select && century_r < 8'h63 && !wr_fire
        |=> century_r == $past(century_r) + 8'h01)
        else $error("century did not step on year wrap");

    a_cent_bcd_step: assert property (
        yr_wrap && i_bcd_select && century_r[3:0] == 4'h9 &&
        century_r[7:4] < 4'h9 && !wr_fire
        |=> century_r[3:0] == 4'h0 &&
        century_r[7:4] == $past(century_r[7:4]) + 4'h1)
        else $error("decimal century digits wrong");

    a_wake_second_ones_locked_write: assert property (
        s_wake_second_ones_write |=> alarm_sec_r == $past(wdata_r[7:0]))
        else $error("alarm seconds write lost");

    a_lock_blocks_write: assert property (
        s_locked_write |=> $stable(month_r) && $stable(year_r) &&
        $stable(century_r))
        else $error("counter changed under lock");

    a_match_needs_en: assert property (
        o_second_match |-> $past(wake_second_match_enable_r) &&
        $past(i_second_count) == $past(alarm_sec_r))
        else $error("seconds match without enable or equality");

    a_match_to_irq: assert property (
        sec_match && !match_r && mask_r[`EVT_SEC_MATCH] |=> o_irq [*2])
        else $error("seconds match did not raise interrupt");

endmodule

// ===== tb/rtc_host_model.sv
// Purpose: processor side of the register bus
// Assumes: one write and one read at most under way, single clock
// Notes:   waits for answers without a bound; the bench watchdog ends a hang
`timescale 1ns/1ps

module rtc_host_model (
    // clock
    input  wire logic        i_sys_clk,
    // write channels
    output logic             o_awvalid,
    input  wire logic        i_awready,
    output logic [11:0]      o_awaddr,
    output logic             o_wvalid,
    input  wire logic        i_wready,
    output logic [31:0]      o_wdata,
    output logic             o_bready,
    input  wire logic        i_bvalid,
    input  wire logic [1:0]  i_bresp,
    // read channels
    output logic             o_arvalid,
    input  wire logic        i_arready,
    output logic [11:0]      o_araddr,
    output logic             o_rready,
    input  wire logic        i_rvalid,
    input  wire logic [31:0] i_rdata,
    input  wire logic [1:0]  i_rresp
);
    initial begin
        o_awvalid = 1'b0;
        o_wvalid  = 1'b0;
        o_bready  = 1'b0;
        o_arvalid = 1'b0;
        o_rready  = 1'b0;
        o_awaddr  = 12'h0;
        o_wdata   = 32'h0;
        o_araddr  = 12'h0;
    end

    // released payloads are inverted so stale values never look valid
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_sys_clk);
        o_awaddr  <= a;
        o_wdata   <= d;
        o_awvalid <= 1'b1;
        o_wvalid  <= 1'b1;
        o_bready  <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (o_awvalid && i_awready) begin
                o_awvalid <= 1'b0;
                o_awaddr  <= ~a;
            end
            if (o_wvalid && i_wready) begin
                o_wvalid <= 1'b0;
                o_wdata  <= ~d;
            end
        end while (!i_bvalid);
        r = i_bresp;
        o_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_sys_clk);
        o_araddr  <= a;
        o_arvalid <= 1'b1;
        o_rready  <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (o_arvalid && i_arready) begin
                o_arvalid <= 1'b0;
                o_araddr  <= ~a;
            end
        end while (!i_rvalid);
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
    endtask
endmodule

// ===== tb/rtc_cal_upper_tb.sv
// Purpose: self-checking bench of the upper calendar block
// Assumes: host model drives the register bus, one clock at 100 MHz
// Notes:   random values from a 16-bit lfsr with a fixed start value
`timescale 1ns/1ps
`include "rtc_cal_upper_params.svh"

module rtc_cal_upper_tb;
    import rtc_cal_upper_pkg::*;
    localparam logic [11:0] A_MON  = {`IDX_MONTH, 2'b00};
    localparam logic [11:0] A_YR   = {`IDX_YEAR, 2'b00};
    localparam logic [11:0] A_CEN  = {`IDX_CENTURY, 2'b00};
    localparam logic [11:0] A_WAKE_SECOND_ONES = {`IDX_ALARM_SEC, 2'b00};
    localparam logic [11:0] A_CTRL = {`IDX_ALARM_CTRL, 2'b00};
    localparam logic [11:0] A_STAT = {`IDX_EVT_STATUS, 2'b00};
    localparam logic [11:0] A_MASK = {`IDX_EVT_MASK, 2'b00};
    logic         sys_clk, rst, day_carry, bcd_select, locked;
    cal_byte_type second_count, m, y, c;
    logic         awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready, second_match, irq, mw, yw;
    logic [11:0]  awaddr, araddr;
    logic [31:0]  wdata, rdata, d;
    logic [1:0]   r;
    axi_resp_type bresp, rresp;
    logic [15:0]  lfsr_r;
    int           fail_count, num_checks;

    rtc_cal_upper i_dut (
        .i_sys_clk(sys_clk), .i_rst(rst),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .i_arprot(3'h0),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_day_carry(day_carry), .i_bcd_select(bcd_select), .i_locked(locked),
        .i_second_count(second_count), .o_second_match(second_match), .o_irq(irq)
    );
    rtc_host_model i_host (
        .i_sys_clk(sys_clk), .o_awvalid(awvalid), .i_awready(awready), .o_awaddr(awaddr),
        .o_wvalid(wvalid), .i_wready(wready), .o_wdata(wdata), .o_bready(bready),
        .i_bvalid(bvalid), .i_bresp(bresp), .o_arvalid(arvalid), .i_arready(arready),
        .o_araddr(araddr), .o_rready(rready), .i_rvalid(rvalid), .i_rdata(rdata),
        .i_rresp(rresp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic cal_byte_type enc(input int n, input logic dec);
        return dec ? cal_byte_type'((n / 10) * 16 + n % 10) : cal_byte_type'(n);
    endfunction
    // decimal carry only looks at the ones digit, like the counters
    function automatic cal_byte_type inc(input cal_byte_type v, input logic dec);
        if (dec && v[3:0] >= 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction
    function automatic int rnd(input int n);
        lfsr_r = lfsr_next(lfsr_r);
        return int'(lfsr_r) % n;
    endfunction

    task automatic check_data(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_flag(input string what, input logic exp, input logic got);
        check_data(what, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        check_data(what, {30'h0, exp}, {30'h0, got});
    endtask
    task automatic wreg(input logic [11:0] a, input cal_byte_type b);
        i_host.wr(a, {24'h0, b}, r);
        check_resp("bresp", RESP_OKAY, r);
    endtask
    task automatic rreg(input string what, input logic [11:0] a, input cal_byte_type e);
        i_host.rd(a, d, r);
        check_data(what, {24'h0, e}, d);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        tick(20000);
        fail_count++;
        results();
    end

    initial begin
        {rst, day_carry, bcd_select, locked} = 4'b1000;
        second_count = 8'h00;
        lfsr_r = 16'h48cf;
        fail_count = 0;
        num_checks = 0;
        tick(5);
        rst <= 1'b0;
        check_flag("irq after reset", 1'b0, irq);
        wreg(A_MASK, 8'h06);
        // carry walk: random legal values, first two are wrap corners
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            bcd_select <= i[0];
            second_count <= cal_byte_type'(rnd(256));
            m = (i < 2) ? 8'h00 : enc(rnd(12) + 1, i[0]);
            y = enc(rnd(100), i[0]);
            c = enc(rnd(100), i[0]);
            if (i == 1) m = enc(12, 1'b1);
            // both codings wrap the year; decimal century carries its ones digit
            if (i < 2) y = enc(99, i[0]);
            if (i == 1) c = enc(rnd(9) * 10 + 9, 1'b1);
            wreg(A_MON, m);
            wreg(A_YR, y);
            wreg(A_CEN, c);
            mw = (m == 8'h00) || (m >= enc(12, i[0]));
            yw = mw && (y >= enc(99, i[0]));
            tick(1);
            day_carry <= 1'b1;
            tick(1);
            day_carry <= 1'b0;
            tick(1);
            check_flag("irq on wrap", mw, irq);
            rreg("month", A_MON, mw ? 8'h01 : inc(m, i[0]));
            rreg("year", A_YR, mw ? (yw ? 8'h00 : inc(y, i[0])) : y);
            rreg("century", A_CEN, !yw ? c : (c >= enc(99, i[0])) ? 8'h00
                                           : inc(c, i[0]));
            i_host.rd(A_STAT, d, r);
            check_data("status", {29'h0, yw, mw, 1'b0}, d & 32'h6);
            wreg(A_STAT, 8'h07);
            check_flag("irq cleared", 1'b0, irq);
        end
        $display("test carry done");
        @(posedge sys_clk);
        bcd_select <= 1'b0;
        wreg(A_MON, 8'h0c);
        wreg(A_YR, 8'h63);
        wreg(A_CEN, 8'h63);
        wreg(A_WAKE_SECOND_ONES, 8'h3b);
        wreg(A_CTRL, 8'h01);
        @(posedge sys_clk);
        locked <= 1'b1;
        wreg(A_MON, 8'h07);
        wreg(A_YR, 8'h11);
        wreg(A_CEN, 8'h21);
        wreg(A_WAKE_SECOND_ONES, 8'h22);
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        rreg("month locked", A_MON, 8'h0c);
        rreg("year locked", A_YR, 8'h63);
        rreg("century locked", A_CEN, 8'h63);
        rreg("alarm seconds", A_WAKE_SECOND_ONES, 8'h22);
        rreg("alarm control", A_CTRL, 8'h00);
        $display("test lock and reset done");
        @(posedge sys_clk);
        locked <= 1'b0;
        bcd_select <= 1'b1;
        wreg(A_WAKE_SECOND_ONES, 8'h59);
        wreg(A_MASK, 8'h01);
        @(posedge sys_clk);
        second_count <= 8'h59;
        tick(3);
        check_flag("match disabled", 1'b0, second_match);
        wreg(A_CTRL, 8'h01);
        tick(2);
        check_flag("match enabled", 1'b1, second_match);
        check_flag("irq on match", 1'b1, irq);
        second_count <= 8'h58;
        tick(2);
        check_flag("match gone", 1'b0, second_match);
        $display("test alarm done");
        i_host.rd(12'hffc, d, r);
        check_resp("rresp unmapped", RESP_SLVERR, r);
        check_data("rdata unmapped", 32'h0, d);
        i_host.wr(12'hffc, 32'h0, r);
        check_resp("bresp unmapped", RESP_SLVERR, r);
        $display("test unmapped done");
        results();
    end
endmodule
